// File: dv/word_store_decode_execute_test.sv
// Bench for the word store core: reference model compared at every result.
// Assumes the core in logic/ and the memory model and checker in dv/.
`timescale 1ns/100ps
module word_store_decode_execute_test;
   logic        clock = 1'b0;
   logic        srst = 1'b1;
   logic        clk_en = 1'b1;
   logic        instr_valid = 1'b0;
   logic        instr_wide = 1'b0;
   logic [31:0] instr_word = 32'h0;
   logic [4:0]  reg_addr = 5'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   wire         instr_ready, evt_done, evt_undef, evt_unpred, mem_wr_valid;
   wire         mem_aligned, mem_unknown, mem_ready;
   wire  [1:0]  evt_redirect;
   wire  [31:0] mem_addr, mem_data, reg_rdata;
   logic [31:0] rf [0:15];
   logic [65:0] exp_q [$];
   integer      seed = 65214;
   integer      err_count = 0;
   integer      cmp_count = 0;
   integer      cyc = 0;
   // ==========================================
   // Design, partner, clock and hang guard
   wsde_core dut_u (.clock, .srst, .clk_en, .instr_valid, .instr_wide, .instr_word,
      .instr_ready, .evt_done, .evt_undef, .evt_unpred, .evt_redirect, .mem_wr_valid,
      .mem_addr, .mem_data, .mem_aligned, .mem_unknown, .mem_ready, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   wsde_mem_model mem_u (.clock, .srst, .mem_wr_valid, .mem_addr, .mem_data,
      .mem_aligned, .mem_unknown, .mem_ready);
   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         test_done();
      end
   end
   // ==========================================
   // Compare, verdict and register port tasks
   task automatic chk(input string nm, input logic [65:0] e, input logic [65:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic test_done();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input int n, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= 5'(n);
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input int n, input logic [31:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= 5'(n);
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk("rdata", e, reg_rdata);
   endtask
   // ==========================================
   // Reference model: single stores may be unaligned, multiples are not
   task automatic e1(input logic [31:0] a, input int t);
      exp_q.push_back({2'b00, a, rf[t]});
   endtask
   task automatic em(input int n, input logic [15:0] l, input logic wb, input logic dn);
      logic [31:0] a;
      int c;
      c = $countones(l[14:0]);
      a = dn ? rf[n] - 4 * c : rf[n];
      for (int i = 0; i < 15; i++) begin
         if (l[i]) begin
            exp_q.push_back({wb && i == n && (l & ((1 << i) - 1)) != 0, 1'b1, a, rf[i]});
            a += 4;
         end
      end
      if (wb) rf[n] = dn ? rf[n] - 4 * c : rf[n] + 4 * c;
   endtask
   // Issue one instruction, await its event, then compare the logged writes
   task automatic go(input logic w, input logic [31:0] iw, input int ev);
      int got;
      got = -1;
      @(posedge clock);
      instr_valid <= 1'b1;
      instr_wide <= w;
      instr_word <= iw;
      @(posedge clock);
      instr_valid <= 1'b0;
      for (int k = 0; k < 300 && got < 0; k++) begin
         #1;
         got = evt_done === 1'b1 ? 0 : evt_undef === 1'b1 ? 1 : evt_unpred === 1'b1 ? 2 :
            (|evt_redirect) === 1'b1 ? 4 + evt_redirect : -1;
         if (got < 0) @(posedge clock);
      end
      chk("event", 66'(ev), 66'(got));
      chk("count", 66'(exp_q.size()), 66'(mem_u.got_q.size()));
      while (exp_q.size() > 0 && mem_u.got_q.size() > 0)
         chk("write", exp_q.pop_front(), mem_u.got_q.pop_front());
      exp_q.delete();
      mem_u.got_q.delete();
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         rf[i] = $random(seed);
         wr(i, rf[i]);
      end
      rd_chk(17, 32'h0);
      // A port write with the enable low must leave the register alone
      @(posedge clock);
      clk_en <= 1'b0;
      wr(5, ~rf[5]);
      clk_en <= 1'b1;
      rd_chk(5, rf[5]);
      go(0, 32'h0, 7);
      e1(rf[2], 3);
      go(0, {16'h0, 5'b01100, 5'd0, 3'd2, 3'd3}, 0);
      e1(rf[2] + 124, 3);
      go(0, {16'h0, 5'b01100, 5'd31, 3'd2, 3'd3}, 0);
      e1(rf[13] + 1020, 4);
      go(0, {16'h0, 5'b10010, 3'd4, 8'hff}, 0);
      e1(rf[2] + rf[1], 5);
      go(0, {16'h0, 7'b0101000, 3'd1, 3'd2, 3'd5}, 0);
      for (int s = 0; s < 4; s++) begin
         e1(rf[6] + (rf[8] << s), 7);
         go(1, {12'hf84, 4'd6, 4'd7, 6'h0, 2'(s), 4'd8}, 0);
      end
      go(1, {12'hf84, 4'd6, 4'd7, 6'h0, 2'd0, 4'd13}, 2);
      go(1, {12'hf84, 4'hf, 4'd7, 6'h0, 2'd0, 4'd8}, 1);
      e1(rf[9] + 4095, 10);
      go(1, {12'hf8c, 4'd9, 4'd10, 12'hfff}, 0);
      go(1, {12'hf8c, 4'hf, 4'd10, 12'hfff}, 1);
      // Every index, add and write-back setting of the byte offset form
      for (int m = 0; m < 8; m++) begin
         logic [31:0] off;
         off = m[1] ? rf[11] + 32'h5a : rf[11] - 32'h5a;
         if (m != 6 && (m[2] || m[0]))
            e1(m[2] ? off : rf[11], 12);
         go(1, {12'hf84, 4'd11, 4'd12, 1'b1, 3'(m), 8'h5a}, m == 6 ? 6 : m[2] | m[0] ? 0 : 1);
         if (m[0]) rf[11] = off;
         rd_chk(11, rf[11]);
      end
      go(1, {12'hf84, 4'd13, 4'd2, 4'b1101, 8'h04}, 5);
      go(1, {12'hf84, 4'hf, 4'd2, 4'b1101, 8'h08}, 1);
      go(1, {12'hf84, 4'd3, 4'hf, 4'b1101, 8'h08}, 2);
      go(1, {12'hf84, 4'd3, 4'd3, 4'b1101, 8'h08}, 2);
      // Multiples: list bits 13 and 15 set in the field must be dropped
      em(11, 16'h100a, 1, 1);
      go(1, {16'he92b, 16'hb00a}, 0);
      rd_chk(11, rf[11]);
      em(2, 16'h4001, 0, 1);
      go(1, {16'he902, 16'h4001}, 0);
      go(1, {16'he92d, 16'h000f}, 5);
      go(1, {16'he92d, 16'h0001}, 5);
      em(3, 16'h00f0, 0, 0);
      go(1, {16'he883, 16'h00f0}, 0);
      rd_chk(3, rf[3]);
      go(1, {16'he883, 16'h0010}, 2);
      go(1, {16'he88f, 16'h00f0}, 2);
      go(1, {16'he8a4, 16'h0030}, 2);
      em(2, 16'h000d, 1, 0);
      go(0, {16'h0, 5'b11000, 3'd2, 8'h0d}, 0);
      rd_chk(2, rf[2]);
      rd_chk(16, 32'h20);
      test_done();
   end
endmodule // word_store_decode_execute_test

bind wsde_core wsde_core_chk chk_u (.clock, .srst, .clk_en, .instr_valid, .instr_ready,
   .evt_done, .evt_undef, .evt_unpred, .evt_redirect, .mem_wr_valid, .mem_addr, .mem_data,
   .mem_aligned, .mem_unknown, .mem_ready);

// File: dv/wsde_core_chk.sv
// Checker for the word store core: timing relations seen at its ports.
// Assumes one clock and a synchronous active-high reset; bound by the bench.
`timescale 1ns/100ps
module wsde_core_chk (
   // Clock and control
   input wire        clock,
   input wire        srst,
   input wire        clk_en,
   // Issue and events
   input wire        instr_valid,
   input wire        instr_ready,
   input wire        evt_done,
   input wire        evt_undef,
   input wire        evt_unpred,
   input wire [1:0]  evt_redirect,
   // Memory write port
   input wire        mem_wr_valid,
   input wire [31:0] mem_addr,
   input wire [31:0] mem_data,
   input wire        mem_aligned,
   input wire        mem_unknown,
   input wire        mem_ready
);
   // ==========================================
   // Properties, all on the one clock domain
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   a_write_hold: assert property (mem_wr_valid && !mem_ready |=>
      mem_wr_valid && $stable(mem_addr) && $stable(mem_data)) else $error("write dropped early");
   a_multi_step: assert property (mem_wr_valid && mem_ready && clk_en && mem_aligned |=>
      !mem_wr_valid || mem_addr == $past(mem_addr) + 32'h4) else $error("multiple step not 4");
   a_done_cause: assert property (evt_done && $past(clk_en) |->
      $past(mem_wr_valid && mem_ready)) else $error("done without last write");
   a_event_cause: assert property ((evt_undef || evt_unpred || evt_redirect != 2'h0)
      && $past(clk_en) |-> $past(instr_valid && instr_ready)) else $error("event without take");
   a_refused_quiet: assert property ((evt_undef || evt_unpred || evt_redirect != 2'h0)
      |-> !mem_wr_valid && !evt_done) else $error("refused form wrote");
   a_undef_first: assert property (evt_undef |-> !evt_unpred && evt_redirect == 2'h0)
      else $error("undefined not alone");
   a_busy_ready: assert property (mem_wr_valid |-> !instr_ready)
      else $error("ready while writing");
   a_start_take: assert property ($rose(mem_wr_valid) |->
      $past(instr_valid && instr_ready && clk_en)) else $error("write without take");
   a_unknown_multi: assert property (mem_unknown |-> mem_wr_valid && mem_aligned)
      else $error("unknown flag outside multiple");
endmodule // wsde_core_chk

// File: dv/wsde_mem_model.sv
// Memory partner: takes word writes with random stalls and logs each one.
// Assumes the core's write port on the same clock; the bench drains got_q.
`timescale 1ns/100ps
module wsde_mem_model (
   // Clock and reset
   input  wire        clock,
   input  wire        srst,
   // Write port
   input  wire        mem_wr_valid,
   input  wire [31:0] mem_addr,
   input  wire [31:0] mem_data,
   input  wire        mem_aligned,
   input  wire        mem_unknown,
   output reg         mem_ready
);
   integer      seed = 65214;
   logic [65:0] got_q [$];
   // ==========================================
   // Accept and log; stalls one edge in four so held writes get exercised
   initial mem_ready = 1'b0;
   always @(posedge clock) begin
      if (mem_wr_valid && mem_ready && !srst)
         got_q.push_back({mem_unknown, mem_aligned, mem_addr, mem_data});
      mem_ready <= !srst && ($random(seed) & 3) != 0;
   end
endmodule // wsde_mem_model

// File: logic/wsde_core.v
// Word store decoder and executor with its own general register file.
// Assumes instructions and memory answers come from logic on the same clock.
// One instruction at a time: a stalled write holds off the next issue.
// Notes on behaviour
// - Ascending register order, lowest at lowest address
// - No write-back leaves base untouched
// - Wide ascending form rejects single register list
// - Wide multiple: base 15, short list unpredictable
// - SP and PC list bits forced zero
// - Base stored unknown if written back and not lowest
// - Descending with write-back on SP is push
// - Descending start is base minus four count
// - Scan 0..14, aligned word, step four
// - Descending write-back subtracts four times count
// - Narrow immediate offset is five bits times four
// - Stack relative store uses SP, byte offset times four
// - Twelve-bit offset, base 15 undefined
// - Index add no write-back goes unprivileged
// - Pre-decrement SP by four is push
// - Base 15 or no index nor write-back undefined
// - Offset address, index select, unaligned write, write-back
// - Source 15 or write-back on same unpredictable
// - Register offset shifted 0..3, no write-back
// - Wide register form undefined and unpredictable cases
`timescale 1ns/100ps
`include "wsde_defs.vh"

module wsde_core (
   // Clock and control
   input  wire        clock,
   input  wire        srst,
   input  wire        clk_en,
   // Instruction issue
   input  wire        instr_valid,
   input  wire        instr_wide,
   input  wire [31:0] instr_word,
   output wire        instr_ready,
   // Outcome events
   output reg         evt_done,
   output reg         evt_undef,
   output reg         evt_unpred,
   output reg  [1:0]  evt_redirect,
   // Memory write port
   output reg         mem_wr_valid,
   output reg  [31:0] mem_addr,
   output reg  [31:0] mem_data,
   output reg         mem_aligned,
   output reg         mem_unknown,
   input  wire        mem_ready,
   // Register port
   input  wire [4:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata
);

   // ==================================================
   // State
   // One-hot: idle, multiple burst, single write
   localparam [2:0] S_IDLE  = 3'b001;
   localparam [2:0] S_MULTI = 3'b010;
   localparam [2:0] S_WRITE = 3'b100;

   // Register file, burst bookkeeping and the status word
   reg [31:0] gpr [0:15];
   reg [2:0]  state;
   reg [15:0] mask;
   reg [3:0]  base_idx;
   reg        do_wb;
   reg [31:0] wb_val;
   reg [31:0] nxt_addr;
   reg        unk_base;
   reg [5:0]  status;

   // Lowest set bit of the scan range 0..14
   function [3:0] lowest;
      input [15:0] m;
      integer      i;
      begin
         lowest = 4'h0;
         for (i = 14; i >= 0; i = i - 1) begin
            if (m[i])
               lowest = i[3:0];
         end
      end
   endfunction

   // Number of selected registers
   function [4:0] count;
      input [15:0] m;
      integer      i;
      begin
         count = 5'h0;
         for (i = 0; i < 16; i = i + 1) begin
            count = count + {4'h0, m[i]};
         end
      end
   endfunction

   // ==================================================
   // Decode
   // The first halfword sits high in the word for wide encodings
   wire [15:0] hw1 = instr_wide ? instr_word[31:16] : instr_word[15:0];
   wire [15:0] hw2 = instr_word[15:0];

   // Decoded fields, valid while the instruction is offered
   reg        d_multi;
   reg        d_store;
   reg        d_desc;
   reg        d_wb;
   reg        d_index;
   reg        d_add;
   reg [3:0]  d_base;
   reg [3:0]  d_src;
   reg [15:0] d_list;
   reg [31:0] d_off;
   reg        d_undef;
   reg        d_unpred;
   reg [1:0]  d_redir;
   reg [3:0]  d_offreg;

   // Classifies the instruction and fills operands; undefined wins over the rest
   always @* begin
      d_multi  = 1'b0;
      d_store  = 1'b0;
      d_desc   = 1'b0;
      d_wb     = 1'b0;
      d_index  = 1'b1;
      d_add    = 1'b1;
      d_base   = 4'h0;
      d_src    = 4'h0;
      d_list   = 16'h0000;
      d_off    = 32'h00000000;
      d_undef  = 1'b0;
      d_unpred = 1'b0;
      d_redir  = `WSDE_RD_NONE;
      d_offreg = hw2[3:0];
      if (!instr_wide) begin
         if (hw1[15:11] == `WSDE_OP_MULTI_N) begin
            // Narrow multiple always writes its base back
            d_multi  = 1'b1;
            d_wb     = 1'b1;
            d_base   = {1'b0, hw1[10:8]};
            d_list   = {8'h00, hw1[7:0]};
            d_unpred = (hw1[7:0] == 8'h00);
         end else if (hw1[15:11] == `WSDE_OP_SINGLE_IMM_N) begin
            // Five-bit word offset, no write-back
            d_store = 1'b1;
            d_base  = {1'b0, hw1[5:3]};
            d_src   = {1'b0, hw1[2:0]};
            d_off   = {25'h0, hw1[10:6], 2'h0};
         end else if (hw1[15:11] == `WSDE_OP_SINGLE_SP_N) begin
            // Stack relative, eight-bit word offset
            d_store = 1'b1;
            d_base  = `WSDE_SP;
            d_src   = {1'b0, hw1[10:8]};
            d_off   = {22'h0, hw1[7:0], 2'h0};
         end else if (hw1[15:9] == `WSDE_OP_SINGLE_REG_N) begin
            // Register offset with no shift
            d_store = 1'b1;
            d_base  = {1'b0, hw1[5:3]};
            d_src   = {1'b0, hw1[2:0]};
            d_offreg = {1'b0, hw1[8:6]};
            d_off   = gpr[{1'b0, hw1[8:6]}];
         end else begin
            d_redir = `WSDE_RD_OTHER;
         end
      end else if ((hw1[15:6] == `WSDE_OP_MULTI_ASC_W || hw1[15:6] == `WSDE_OP_MULTI_DESC_W)
                   && !hw1[4]) begin
         // Wide multiple; list bits for the stack pointer and counter are dropped
         d_multi = 1'b1;
         d_desc  = (hw1[15:6] == `WSDE_OP_MULTI_DESC_W);
         d_wb    = hw1[5];
         d_base  = hw1[3:0];
         d_list  = {1'b0, hw2[14], 1'b0, hw2[12:0]};
         if (d_desc && d_wb && d_base == `WSDE_SP)
            d_redir = `WSDE_RD_PUSH;
         d_unpred = (d_base == `WSDE_PC) || (count(d_list) < 5'h2)
                    || (d_wb && d_list[d_base]);
      end else if (hw1[15:4] == `WSDE_OP_SINGLE_I12) begin
         // Twelve-bit offset, always added, never written back
         d_store  = 1'b1;
         d_base   = hw1[3:0];
         d_src    = hw2[15:12];
         d_off    = {20'h0, hw2[11:0]};
         d_undef  = (d_base == `WSDE_PC);
         d_unpred = (d_src == `WSDE_PC);
      end else if (hw1[15:4] == `WSDE_OP_SINGLE_I8R && hw2[11]) begin
         // Byte offset with separate index, add and write-back bits
         d_store = 1'b1;
         d_base  = hw1[3:0];
         d_src   = hw2[15:12];
         d_index = hw2[10];
         d_add   = hw2[9];
         d_wb    = hw2[8];
         d_off   = {24'h0, hw2[7:0]};
         if (d_index && d_add && !d_wb)
            d_redir = `WSDE_RD_UNPRIV;
         else if (d_base == `WSDE_SP && d_index && !d_add && d_wb
                  && hw2[7:0] == `WSDE_PUSH_IMM)
            d_redir = `WSDE_RD_PUSH;
         d_undef  = (d_base == `WSDE_PC) || (!d_index && !d_wb);
         d_unpred = (d_src == `WSDE_PC)
                    || (d_wb && d_base == d_src);
      end else if (hw1[15:4] == `WSDE_OP_SINGLE_I8R && hw2[11:6] == 6'h00) begin
         // Register offset shifted by up to three places
         d_store  = 1'b1;
         d_base   = hw1[3:0];
         d_src    = hw2[15:12];
         d_off    = gpr[hw2[3:0]] << hw2[5:4];
         d_undef  = (d_base == `WSDE_PC);
         d_unpred = (d_src == `WSDE_PC) || (d_offreg == `WSDE_SP)
                    || (d_offreg == `WSDE_PC);
      end else begin
         d_redir = `WSDE_RD_OTHER;
      end
   end

   // ==================================================
   // Address arithmetic
   wire [31:0] base_val = gpr[d_base];
   wire [31:0] span     = {25'h0, count(d_list), 2'h0};
   wire [31:0] off_addr = d_add ? base_val + d_off : base_val - d_off;
   wire [3:0]  first    = lowest(d_list);
   wire        take     = instr_valid && (state == S_IDLE) && clk_en;
   wire        run      = !d_undef && !d_unpred && (d_redir == `WSDE_RD_NONE);
   // Redirected forms hand over before any unpredictable check applies
   wire        unpr_evt = !d_undef && d_unpred && (d_redir == `WSDE_RD_NONE);
   // Register now on the bus is cleared from the pending set
   wire [15:0] rest     = mask & ~(16'h0001 << lowest(mask));
   wire        last     = (rest == 16'h0000);

   // Ready only when idle; taking needs the enable as well
   assign instr_ready = (state == S_IDLE);

   // ==================================================
   // Sequencer and memory side
   always @(posedge clock) begin
      // Reset clears outputs; the register file keeps its contents
      if (srst) begin
         state        <= S_IDLE;
         mask         <= 16'h0000;
         base_idx     <= 4'h0;
         do_wb        <= 1'b0;
         wb_val       <= 32'h00000000;
         nxt_addr     <= 32'h00000000;
         unk_base     <= 1'b0;
         status       <= 6'h00;
         evt_done     <= 1'b0;
         evt_undef    <= 1'b0;
         evt_unpred   <= 1'b0;
         evt_redirect <= `WSDE_RD_NONE;
         mem_wr_valid <= 1'b0;
         mem_addr     <= 32'h00000000;
         mem_data     <= 32'h00000000;
         mem_aligned  <= 1'b0;
         mem_unknown  <= 1'b0;
      end else if (clk_en) begin
         // Events are pulses, cleared every enabled cycle
         evt_done     <= 1'b0;
         evt_undef    <= 1'b0;
         evt_unpred   <= 1'b0;
         evt_redirect <= `WSDE_RD_NONE;
         case (state)
            S_IDLE: begin
               if (take) begin
                  evt_undef    <= d_undef;
                  evt_unpred   <= unpr_evt;
                  evt_redirect <= d_undef ? `WSDE_RD_NONE : d_redir;
                  status[4:1]  <= {d_undef ? `WSDE_RD_NONE : d_redir, unpr_evt, d_undef};
                  base_idx     <= d_base;
                  if (run && d_multi) begin
                     // Write-back with base in list but not lowest: its stored word is unknown
                     unk_base     <= d_wb && d_list[d_base] && (first != d_base);
                     mask         <= d_list;
                     do_wb        <= d_wb;
                     wb_val       <= d_desc ? base_val - span : base_val + span;
                     mem_addr     <= d_desc ? base_val - span : base_val;
                     mem_data     <= gpr[first];
                     mem_unknown  <= d_wb && (first == d_base) && 1'b0;
                     nxt_addr     <= (d_desc ? base_val - span : base_val)
                                     + `WSDE_WORD_BYTES;
                     mem_aligned  <= 1'b1;
                     mem_wr_valid <= 1'b1;
                     status[`WSDE_ST_BUSY] <= 1'b1;
                     state        <= S_MULTI;
                  end else if (run && d_store) begin
                     // Single word: unaligned allowed, base updated at the end
                     mask         <= 16'h0000;
                     do_wb        <= d_wb;
                     wb_val       <= off_addr;
                     mem_addr     <= d_index ? off_addr : base_val;
                     mem_data     <= gpr[d_src];
                     mem_unknown  <= 1'b0;
                     mem_aligned  <= 1'b0;
                     mem_wr_valid <= 1'b1;
                     status[`WSDE_ST_BUSY] <= 1'b1;
                     state        <= S_WRITE;
                  end else begin
                     // Refused or redirected forms raise only their event
                     evt_done <= 1'b0;
                  end
               end
            end
            S_MULTI: begin
               // Each accepted word retires the lowest pending register
               if (mem_ready) begin
                  mask <= rest;
                  if (last) begin
                     mem_wr_valid <= 1'b0;
                     mem_unknown  <= 1'b0;
                     evt_done     <= 1'b1;
                     status[`WSDE_ST_BUSY] <= 1'b0;
                     status[`WSDE_ST_UNKNOWN] <= unk_base;
                     state        <= S_IDLE;
                  end else begin
                     // Next register upward, next word upward
                     mem_addr    <= nxt_addr;
                     nxt_addr    <= nxt_addr + `WSDE_WORD_BYTES;
                     mem_data    <= gpr[lowest(rest)];
                     mem_unknown <= unk_base && (lowest(rest) == base_idx);
                  end
               end
            end
            S_WRITE: begin
               // One word; write-back lands on the accepting edge
               if (mem_ready) begin
                  mem_wr_valid <= 1'b0;
                  evt_done     <= 1'b1;
                  status[`WSDE_ST_BUSY] <= 1'b0;
                  status[`WSDE_ST_UNKNOWN] <= 1'b0;
                  state        <= S_IDLE;
               end
            end
            default: begin
               // Unused codes fall back to idle
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ==================================================
   // General registers: base write-back beats a port write to the same register
   wire wb_fire = clk_en && mem_ready && do_wb
                  && ((state == S_WRITE) || (state == S_MULTI && last));

   always @(posedge clock) begin
      if (wb_fire)
         gpr[base_idx] <= wb_val;
      // A clashing port write is dropped so the base update stays whole
      if (clk_en && reg_wr && !reg_addr[4] && !(wb_fire && reg_addr[3:0] == base_idx))
         gpr[reg_addr[3:0]] <= reg_wdata;
   end

   // ==================================================
   // Register port read, one cycle after the strobe
   always @(posedge clock) begin
      if (srst) begin
         reg_rdata <= 32'h00000000;
      end else if (clk_en) begin
         // Unmapped indices read as zero
         if (reg_rd && !reg_addr[4])
            reg_rdata <= gpr[reg_addr[3:0]];
         else if (reg_rd && reg_addr == `WSDE_IDX_STATUS)
            reg_rdata <= {26'h0, status};
         else
            reg_rdata <= 32'h00000000;
      end
   end

endmodule // wsde_core

// File: logic/wsde_defs.vh
// Constants for the word store decode and execute block.
// Assumes inclusion by bare name from logic/ files only.
`ifndef WSDE_DEFS_VH
`define WSDE_DEFS_VH
// ==================================================
// Encodings (top bits of the first halfword)
`define WSDE_OP_MULTI_N      5'h18
`define WSDE_OP_SINGLE_IMM_N 5'h0c
`define WSDE_OP_SINGLE_SP_N  5'h12
`define WSDE_OP_SINGLE_REG_N 7'h28
`define WSDE_OP_MULTI_ASC_W  10'h3a2
`define WSDE_OP_MULTI_DESC_W 10'h3a4
`define WSDE_OP_SINGLE_I12   12'hf8c
`define WSDE_OP_SINGLE_I8R   12'hf84
// ==================================================
// Register numbers and special values
`define WSDE_SP           4'hd
`define WSDE_PC           4'hf
`define WSDE_SCAN_LAST    4'he
`define WSDE_PUSH_IMM     8'h04
`define WSDE_WORD_BYTES   32'h00000004
// ==================================================
// Register port map: index 0..15 general registers, 16 status
`define WSDE_IDX_STATUS   5'h10
`define WSDE_ST_BUSY      0
`define WSDE_ST_UNDEF     1
`define WSDE_ST_UNPRED    2
`define WSDE_ST_REDIR_LO  3
`define WSDE_ST_UNKNOWN   5
// ==================================================
// Redirect codes
`define WSDE_RD_NONE      2'h0
`define WSDE_RD_PUSH      2'h1
`define WSDE_RD_UNPRIV    2'h2
`define WSDE_RD_OTHER     2'h3
`endif
